// *** core/pxr_defs.svh ***
// Offsets, field positions, reset values and rule summary of the config bank.
// Behaviour
// - Second output divider bits 3:0 are held in register p2_low_and_test_select bits 7:4.
// - Second output divider register bits are ignored unless override bit is set.
// - Register p2_low_and_test_select bit 3 clear: lock pin shows PLL lock, the default.
// - Register p2_low_and_test_select bit 3 set: lock pin outputs the selected test signal.
// - Test select: oscillator, pump-up half, detector reference half, feedback half.
// - First divider code 001 to 111 gives 5 to 11; 000 is invalid.
// - First output divider field is ignored unless override bit is set.
// - Receiver reset bit clears itself after a one is written; default zero.
// - Receiver reset reinitialises detectors, dividers, switchover and oscillator.
// - Band gap trim defaults to zero and acts only when its enable is one.
// - Band gap enable clear: device picks voltage; set: trim field defines it.
// - Crystal auto bit set by default picks capacitance; clear uses the field.
// - Capacitor code is inverted binary, quarter picofarad steps, zero is maximum.
// - Capacitor field is ignored unless the crystal auto bit is zero.
// - Register 0x14 bit 2 picks divider source: pins when zero, registers when one.
// - Upper second divider bits sit in register 0x16 bits 5:0.
`ifndef PXR_DEFS_SVH
`define PXR_DEFS_SVH
`define PXR_OFS_OVR 8'h14
`define PXR_OFS_P2HI 8'h16
`define PXR_OFS_TEST 8'h17
`define PXR_OFS_P0 8'h18
`define PXR_OFS_RXBG 8'h1a
`define PXR_OFS_CRYS 8'h1b
`define PXR_BIT_OVR 2
`define PXR_P2HI_MSB 5
`define PXR_P2LO_MSB 7
`define PXR_P2LO_LSB 4
`define PXR_BIT_TEN 3
`define PXR_TMUX_MSB 2
`define PXR_TMUX_LSB 1
`define PXR_P0_MSB 7
`define PXR_P0_LSB 5
`define PXR_BIT_RXRST 7
`define PXR_BG_MSB 6
`define PXR_BG_LSB 2
`define PXR_BIT_BGEN 0
`define PXR_BIT_CAUTO 7
`define PXR_CCAP_MSB 5
`define PXR_RST_OVR 1'b0
`define PXR_RST_P2HI 6'h00
`define PXR_RST_P2LO 4'h0
`define PXR_RST_TEN 1'b0
`define PXR_RST_TMUX 2'h0
`define PXR_RST_P0 3'h1
`define PXR_P0_INVALID 3'h0
`define PXR_RST_BG 5'h00
`define PXR_RST_BGEN 1'b0
`define PXR_RST_CAUTO 1'b1
`define PXR_RST_CCAP 6'h00
`endif

// *** core/pxr_pkg.sv ***
// Types shared by the configuration register bank and its test multiplexer.
package pxr_pkg;

  // Register access request from the serial control port engine.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pxr_bus_req_s;

  // Test multiplexer selection codes.
  typedef enum logic [1:0] {
    PXR_TM_OSC = 2'h0,
    PXR_TM_UP = 2'h1,
    PXR_TM_REF = 2'h2,
    PXR_TM_FB = 2'h3
  } pxr_tmux_e;

  // Asynchronous analog signals that may be routed to the lock pin.
  typedef struct packed {
    logic pll_locked;
    logic crystal_osc_output;
    logic pump_up;
    logic detector_ref;
    logic feedback_clock;
  } pxr_tsrc_s;

  // Effective settings handed to the analog and divider logic.
  typedef struct packed {
    logic [2:0] p0_code;
    logic [9:0] p2_div;
    logic rx_reset;
    logic bg_manual;
    logic [4:0] bg_trim;
    logic cap_manual;
    logic [5:0] cap_code;
  } pxr_cfg_s;

  // Whole state of the register bank.
  typedef struct packed {
    logic alive;
    logic ovr;
    logic [5:0] p2_hi;
    logic [3:0] p2_lo;
    logic test_en;
    logic [1:0] tmux;
    logic [2:0] p0;
    logic rx_rst;
    logic [4:0] bg;
    logic bg_en;
    logic cap_auto;
    logic [5:0] cap;
    logic [7:0] rdata;
    logic rvalid;
    pxr_cfg_s cfg;
  } pxr_regs_s;

  // Whole state of the test multiplexer.
  typedef struct packed {
    pxr_tsrc_s s1;
    pxr_tsrc_s s2;
    pxr_tsrc_s s2d;
    logic up_half;
    logic ref_half;
    logic fb_half;
    logic lock_pin;
  } pxr_tmux_st_s;

endpackage

// *** core/pxr_tmux.sv ***
// Lock pin driver with test multiplexer and halved test clocks.
`timescale 1ns/100ps
`default_nettype none
module pxr_tmux (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic test_en_i,
  input wire pxr_pkg::pxr_tmux_e sel_i,
  input wire pxr_pkg::pxr_tsrc_s tsrc_i,
  output logic lock_pin_o
);
  import pxr_pkg::*;

  pxr_tmux_st_s st_ff;
  pxr_tmux_st_s nxt_st;
  logic test_bit;

  // Sources are sampled at the system clock, so only test clocks well below
  // half the system rate are reproduced faithfully; that is the trade-off.
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.s1 = tsrc_i;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s2d = st_ff.s2;
    if (st_ff.s2.pump_up && !st_ff.s2d.pump_up)
      nxt_st.up_half = ~st_ff.up_half;
    if (st_ff.s2.detector_ref && !st_ff.s2d.detector_ref)
      nxt_st.ref_half = ~st_ff.ref_half;
    if (st_ff.s2.feedback_clock && !st_ff.s2d.feedback_clock)
      nxt_st.fb_half = ~st_ff.fb_half;
    unique case (sel_i)
      PXR_TM_OSC: test_bit = st_ff.s2.crystal_osc_output;
      PXR_TM_UP: test_bit = st_ff.up_half;
      PXR_TM_REF: test_bit = st_ff.ref_half;
      PXR_TM_FB: test_bit = st_ff.fb_half;
    endcase
    nxt_st.lock_pin = test_en_i ? test_bit : st_ff.s2.pll_locked;
  end

  // State register.
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign lock_pin_o = st_ff.lock_pin;

  a_lock_status: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    !test_en_i |=> lock_pin_o == $past(st_ff.s2.pll_locked))
    else $error("Lock pin does not follow lock status.");
  a_test_osc: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    test_en_i && sel_i == PXR_TM_OSC
      |=> lock_pin_o == $past(st_ff.s2.crystal_osc_output))
    else $error("Lock pin does not carry the oscillator test signal.");
  a_half_toggle: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    st_ff.s2.feedback_clock && !st_ff.s2d.feedback_clock
      |=> st_ff.fb_half != $past(st_ff.fb_half))
    else $error("Feedback half clock did not toggle.");
endmodule
`default_nettype wire

// *** core/pxr_regs.sv ***
// Configuration register bank for output dividers, test port and trims.
`timescale 1ns/100ps
`default_nettype none
`include "pxr_defs.svh"
module pxr_regs (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire pxr_pkg::pxr_bus_req_s req_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  input wire logic [2:0] pin_p0_i,
  input wire logic [9:0] pin_p2_i,
  input wire pxr_pkg::pxr_tsrc_s tsrc_i,
  output var pxr_pkg::pxr_cfg_s cfg_o,
  output logic lock_pin_o
);
  import pxr_pkg::*;

  localparam pxr_regs_s RST_ST = '{
    alive: 1'b0,
    ovr: `PXR_RST_OVR,
    p2_hi: `PXR_RST_P2HI,
    p2_lo: `PXR_RST_P2LO,
    test_en: `PXR_RST_TEN,
    tmux: `PXR_RST_TMUX,
    p0: `PXR_RST_P0,
    rx_rst: 1'b0,
    bg: `PXR_RST_BG,
    bg_en: `PXR_RST_BGEN,
    cap_auto: `PXR_RST_CAUTO,
    cap: `PXR_RST_CCAP,
    rdata: 8'h00,
    rvalid: 1'b0,
    cfg: '{
      p0_code: `PXR_RST_P0,
      p2_div: 10'h000,
      rx_reset: 1'b0,
      bg_manual: 1'b0,
      bg_trim: 5'h00,
      cap_manual: 1'b0,
      cap_code: 6'h00
    }
  };

  pxr_regs_s st_ff;
  pxr_regs_s nxt_st;

  // True when the request is a write to the given offset.
  function automatic logic wr_hit(input pxr_bus_req_s r,
                                  input logic [7:0] ofs);
    wr_hit = r.wr && (r.addr == ofs);
  endfunction

  // Read view of one register; unmapped offsets and unused bits give zero.
  function automatic logic [7:0] rd_word(input pxr_regs_s s,
                                         input logic [7:0] addr);
    logic [7:0] w;
    w = 8'h00;
    unique case (addr)
      `PXR_OFS_OVR:
        w[`PXR_BIT_OVR] = s.ovr;
      `PXR_OFS_P2HI:
        w[`PXR_P2HI_MSB:0] = s.p2_hi;
      `PXR_OFS_TEST:
      begin
        w[`PXR_P2LO_MSB:`PXR_P2LO_LSB] = s.p2_lo;
        w[`PXR_BIT_TEN] = s.test_en;
        w[`PXR_TMUX_MSB:`PXR_TMUX_LSB] = s.tmux;
      end
      `PXR_OFS_P0:
        w[`PXR_P0_MSB:`PXR_P0_LSB] = s.p0;
      `PXR_OFS_RXBG:
      begin
        w[`PXR_BIT_RXRST] = s.rx_rst;
        w[`PXR_BG_MSB:`PXR_BG_LSB] = s.bg;
        w[`PXR_BIT_BGEN] = s.bg_en;
      end
      `PXR_OFS_CRYS:
      begin
        w[`PXR_BIT_CAUTO] = s.cap_auto;
        w[`PXR_CCAP_MSB:0] = s.cap;
      end
      default:
        w = 8'h00;
    endcase
    rd_word = w;
  endfunction

  // Next state: register writes, read capture and the effective settings.
  // The settings are derived from the next register values so that they
  // change on the same edge as the register itself.
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.alive = 1'b1;
    nxt_st.rvalid = req_i.rd;
    nxt_st.rx_rst = 1'b0;
    if (req_i.rd)
      nxt_st.rdata = rd_word(st_ff, req_i.addr);
    if (wr_hit(req_i, `PXR_OFS_OVR))
      nxt_st.ovr = req_i.wdata[`PXR_BIT_OVR];
    if (wr_hit(req_i, `PXR_OFS_P2HI))
      nxt_st.p2_hi = req_i.wdata[`PXR_P2HI_MSB:0];
    if (wr_hit(req_i, `PXR_OFS_TEST))
    begin
      nxt_st.p2_lo = req_i.wdata[`PXR_P2LO_MSB:`PXR_P2LO_LSB];
      nxt_st.test_en = req_i.wdata[`PXR_BIT_TEN];
      nxt_st.tmux = req_i.wdata[`PXR_TMUX_MSB:`PXR_TMUX_LSB];
    end
    // The invalid code is dropped so the register path never hands it to the divider.
    if (wr_hit(req_i, `PXR_OFS_P0) &&
        req_i.wdata[`PXR_P0_MSB:`PXR_P0_LSB] != `PXR_P0_INVALID)
      nxt_st.p0 = req_i.wdata[`PXR_P0_MSB:`PXR_P0_LSB];
    // A one written in the clearing cycle keeps the reset asserted.
    if (wr_hit(req_i, `PXR_OFS_RXBG))
    begin
      nxt_st.rx_rst = req_i.wdata[`PXR_BIT_RXRST];
      nxt_st.bg = req_i.wdata[`PXR_BG_MSB:`PXR_BG_LSB];
      nxt_st.bg_en = req_i.wdata[`PXR_BIT_BGEN];
    end
    // Bit 6 is not stored, so a stray one from software is harmless.
    if (wr_hit(req_i, `PXR_OFS_CRYS))
    begin
      nxt_st.cap_auto = req_i.wdata[`PXR_BIT_CAUTO];
      nxt_st.cap = req_i.wdata[`PXR_CCAP_MSB:0];
    end
    nxt_st.cfg.p0_code = nxt_st.ovr ? nxt_st.p0 : pin_p0_i;
    nxt_st.cfg.p2_div = nxt_st.ovr ? {nxt_st.p2_hi, nxt_st.p2_lo}
                                   : pin_p2_i;
    nxt_st.cfg.rx_reset = nxt_st.rx_rst;
    nxt_st.cfg.bg_manual = nxt_st.bg_en;
    nxt_st.cfg.bg_trim = nxt_st.bg_en ? nxt_st.bg : 5'h00;
    nxt_st.cfg.cap_manual = ~nxt_st.cap_auto;
    // The code goes out raw; the array decodes the inverted weighting.
    nxt_st.cfg.cap_code = nxt_st.cap_auto ? 6'h00 : nxt_st.cap;
  end

  // State register.
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      st_ff <= RST_ST;
    else
      st_ff <= nxt_st;
  end

  // Lock pin and test multiplexer.
  pxr_tmux u_tmux (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .test_en_i(st_ff.test_en),
    .sel_i(pxr_tmux_e'(st_ff.tmux)),
    .tsrc_i(tsrc_i),
    .lock_pin_o(lock_pin_o)
  );

  // Outputs straight from the state register.
  assign rdata_o = st_ff.rdata;
  assign rvalid_o = st_ff.rvalid;
  assign cfg_o = st_ff.cfg;

  // Write of a given offset.
  sequence s_wr(logic [7:0] ofs);
    req_i.wr && req_i.addr == ofs;
  endsequence

  // Read of a given offset.
  sequence s_rd(logic [7:0] ofs);
    req_i.rd && req_i.addr == ofs;
  endsequence

  // Override already set when a divider write lands, so the write shows.
  sequence s_ovr_on;
    st_ff.ovr;
  endsequence

  // Low divider bits reach the effective divider under override.
  a_p2_low_field: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    s_wr(`PXR_OFS_TEST) ##0 s_ovr_on
      |=> cfg_o.p2_div[3:0] == $past(req_i.wdata[7:4]))
    else $error("Low divider bits not taken from the test register.");

  // Without override the divider follows the pins, one cycle late.
  a_p2_pins: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    st_ff.alive && !nxt_st.ovr |=> cfg_o.p2_div == $past(pin_p2_i))
    else $error("Second divider not taken from the pins.");

  // Upper divider bits reach the effective divider under override.
  a_p2_high_field: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    s_wr(`PXR_OFS_P2HI) ##0 s_ovr_on
      |=> cfg_o.p2_div[9:4] == $past(req_i.wdata[5:0]))
    else $error("Upper divider bits not taken from their register.");

  // The register path never hands the divider the invalid code.
  a_p0_valid: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    st_ff.ovr |-> cfg_o.p0_code != `PXR_P0_INVALID)
    else $error("First divider shows the invalid code.");

  // A write of the invalid code leaves the stored code untouched.
  a_p0_invalid_kept: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    s_wr(`PXR_OFS_P0) ##0 (req_i.wdata[7:5] == 3'h0)
      |=> st_ff.p0 == $past(st_ff.p0))
    else $error("Invalid first divider code was stored.");

  // Without override the first divider follows the pins.
  a_p0_pins: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    st_ff.alive && !nxt_st.ovr |=> cfg_o.p0_code == $past(pin_p0_i))
    else $error("First divider not taken from the pins.");

  // With override the registers decide both dividers.
  a_ovr_source: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    st_ff.ovr |-> cfg_o.p0_code == st_ff.p0 &&
      cfg_o.p2_div == {st_ff.p2_hi, st_ff.p2_lo})
    else $error("Override does not select the register values.");

  // A written one gives exactly one cycle of receiver reset.
  a_rx_pulse: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    s_wr(`PXR_OFS_RXBG) ##0 req_i.wdata[7] ##1 !req_i.wr
      |-> cfg_o.rx_reset ##1 !cfg_o.rx_reset)
    else $error("Receiver reset did not pulse for one cycle.");

  // Receiver reset never stays up without a fresh write.
  a_rx_selfclear: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    st_ff.rx_rst && !(req_i.wr && req_i.addr == `PXR_OFS_RXBG)
      |=> !st_ff.rx_rst)
    else $error("Receiver reset bit did not clear itself.");

  // The reference hardware sees exactly the stored reset bit.
  a_rx_drive: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    cfg_o.rx_reset == st_ff.rx_rst)
    else $error("Receiver reset output differs from its bit.");

  // The trim reaches the band gap only while enabled.
  a_bg_gate: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    !st_ff.bg_en |-> cfg_o.bg_trim == 5'h00 && !cfg_o.bg_manual)
    else $error("Band gap trim leaks while disabled.");

  // A write with enable set applies the written trim on the next edge.
  a_bg_apply: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    s_wr(`PXR_OFS_RXBG) ##0 req_i.wdata[0]
      |=> cfg_o.bg_manual && cfg_o.bg_trim == $past(req_i.wdata[6:2]))
    else $error("Band gap trim not applied.");

  // Automatic capacitance mode hides the field.
  a_cap_auto: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    st_ff.cap_auto |-> !cfg_o.cap_manual && cfg_o.cap_code == 6'h00)
    else $error("Capacitance field leaks in automatic mode.");

  // The written code is passed raw, so all ones means no capacitance.
  a_cap_code: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    s_wr(`PXR_OFS_CRYS) ##0 !req_i.wdata[7]
      |=> cfg_o.cap_manual && cfg_o.cap_code == $past(req_i.wdata[5:0]))
    else $error("Capacitance code not passed unchanged.");

  // Manual mode always shows the stored field.
  a_cap_manual: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    !st_ff.cap_auto |-> cfg_o.cap_code == st_ff.cap)
    else $error("Stored capacitance field not applied.");

  // Unused registers 0x19 and 0x1c to 0x1e read back as zero one cycle after the request.
  a_unused_zero: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    req_i.rd && (req_i.addr inside {8'h19, 8'h1c, 8'h1d, 8'h1e})
      |=> rvalid_o && rdata_o == 8'h00)
    else $error("Unused register did not read as zero.");

  // Unused bit 6 of the capacitance register reads back as zero.
  a_unused_bits: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    s_rd(`PXR_OFS_CRYS) |=> rdata_o[6] == 1'b0)
    else $error("Unused capacitance register bit read as one.");

  // Test mode selection comes from the register bit.
  a_test_enable: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    s_wr(`PXR_OFS_TEST) |=> st_ff.test_en == $past(req_i.wdata[3]) &&
      st_ff.tmux == $past(req_i.wdata[2:1]))
    else $error("Test port controls not stored.");

  // Every read is answered exactly one cycle later, and only then.
  a_rd_strobe: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    st_ff.alive |-> rvalid_o == $past(req_i.rd))
    else $error("Read strobe not one cycle after the request.");

  // Read data hold between reads, so a slow reader still sees them.
  a_rd_hold: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    !req_i.rd |=> $stable(rdata_o))
    else $error("Read data changed without a read.");

  // The override bit is stored from its own write.
  a_ovr_store: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    s_wr(`PXR_OFS_OVR) |=> st_ff.ovr == $past(req_i.wdata[2]))
    else $error("Override bit not stored.");

  // A valid first divider code is stored as written.
  a_p0_store: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    s_wr(`PXR_OFS_P0) ##0 (req_i.wdata[7:5] != 3'h0)
      |=> st_ff.p0 == $past(req_i.wdata[7:5]))
    else $error("Valid first divider code not stored.");

  // A pending receiver reset still reads back as one.
  a_rx_readback: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    s_rd(`PXR_OFS_RXBG) |=> rdata_o[7] == $past(st_ff.rx_rst))
    else $error("Receiver reset bit read back wrongly.");

  // Trim and its enable are stored from a write of their register.
  a_bg_store: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    s_wr(`PXR_OFS_RXBG) |=> st_ff.bg == $past(req_i.wdata[6:2]) &&
      st_ff.bg_en == $past(req_i.wdata[0]))
    else $error("Band gap trim or enable not stored.");

  // Capacitance mode bit and field are stored; bit 6 is dropped.
  a_cap_store: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    s_wr(`PXR_OFS_CRYS) |=> st_ff.cap_auto == $past(req_i.wdata[7]) &&
      st_ff.cap == $past(req_i.wdata[5:0]))
    else $error("Capacitance controls not stored.");

  // Unused low bits of the first divider register read as zero.
  a_unused_low: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    s_rd(`PXR_OFS_P0) |=> rdata_o[4:0] == 5'h00)
    else $error("Unused first divider bits read as one.");

  // Bit 1 of the trim register is unused and reads as zero.
  a_unused_trim: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    s_rd(`PXR_OFS_RXBG) |=> rdata_o[1] == 1'b0)
    else $error("Unused trim register bit read as one.");

  // Bit 0 of the test register is unused and reads as zero.
  a_unused_test: assert property (@(posedge clk_sys_i)
    disable iff (!arst_n_i)
    s_rd(`PXR_OFS_TEST) |=> rdata_o[0] == 1'b0)
    else $error("Unused test register bit read as one.");
endmodule
`default_nettype wire

// *** verif/pxr_regs_tb.sv ***
// Self-checking testbench of the configuration register bank.
`timescale 1ns/100ps
`default_nettype none
module pxr_regs_tb;
  import pxr_pkg::*;
  logic clk_sys_i;
  logic arst_n_i;
  pxr_bus_req_s req;
  logic [7:0] rdata;
  logic rvalid;
  logic [2:0] pin_p0;
  logic [9:0] pin_p2;
  pxr_tsrc_s tsrc;
  pxr_cfg_s cfg;
  logic lock_pin;
  int fail_count;
  int num_checks;
  logic [31:0] lfsr;
  logic ovr, ten, rx, bgen, cauto;
  logic [5:0] p2hi, cap;
  logic [3:0] p2lo;
  logic [1:0] tmux;
  logic [2:0] p0;
  logic [4:0] bg;
  logic [7:0] ra, rd_dat, cnt;
  logic last;

  pxr_regs pxr_regs_i (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid), .pin_p0_i(pin_p0),
    .pin_p2_i(pin_p2), .tsrc_i(tsrc), .cfg_o(cfg), .lock_pin_o(lock_pin));

  // The 40 MHz system clock.
  initial
  begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  // Pseudo-random source; a fixed start keeps runs repeatable.
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Expected read data; unused bits and unmapped offsets give zero.
  function automatic logic [7:0] exp_rd(input logic [7:0] a, input logic r);
    case (a)
      8'h14: return {5'h00, ovr, 2'h0};
      8'h16: return {2'h0, p2hi};
      8'h17: return {p2lo, ten, tmux, 1'b0};
      8'h18: return {p0, 5'h00};
      8'h1a: return {r, bg, 1'b0, bgen};
      8'h1b: return {cauto, 1'b0, cap};
      default: return 8'h00;
    endcase
  endfunction

  // Expected effective settings from the bench's copy of the registers.
  function automatic pxr_cfg_s exp_cfg(input logic r);
    pxr_cfg_s c;
    c.p0_code = ovr ? p0 : pin_p0;
    c.p2_div = ovr ? {p2hi, p2lo} : pin_p2;
    c.rx_reset = r;
    c.bg_manual = bgen;
    c.bg_trim = bgen ? bg : 5'h00;
    c.cap_manual = ~cauto;
    c.cap_code = cauto ? 6'h00 : cap;
    return c;
  endfunction

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp,
                          input string what);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: %s %h not %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: %s %b not %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_cfg(input pxr_cfg_s got, input pxr_cfg_s exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: settings %h not %h", $time, got, exp);
    end
  endtask

  // One write; entered at a falling edge, leaves the request for the next.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    pin_p0 = lfsr[2:0];
    pin_p2 = lfsr[12:3];
    lfsr = lfsr_next(lfsr);
    rx = 1'b0;
    case (a)
      8'h14: ovr = d[2];
      8'h16: p2hi = d[5:0];
      8'h17: {p2lo, ten, tmux} = d[7:1];
      8'h18: if (d[7:5] != 3'h0) p0 = d[7:5];
      8'h1a: {rx, bg, bgen} = {d[7:2], d[0]};
      8'h1b: {cauto, cap} = {d[7], d[5:0]};
      default: ;
    endcase
    @(negedge clk_sys_i);
    chk_bit(rvalid, 1'b0, "rvalid after write");
    chk_cfg(cfg, exp_cfg(rx));
  endtask

  // One read; a receiver reset set just before still reads as one.
  task automatic rd(input logic [7:0] a);
    logic r;
    r = rx;
    rx = 1'b0;
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: lfsr[7:0]};
    @(negedge clk_sys_i);
    chk_bit(rvalid, 1'b1, "rvalid");
    chk_byte(rdata, exp_rd(a, r), "read data");
    chk_cfg(cfg, exp_cfg(1'b0));
  endtask

  task automatic idle;
    req = '0;
    @(negedge clk_sys_i);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Cuts a hang short well above the expected run length.
  initial
  begin
    #50000;
    fail_count++;
    $display("unexpected at %0t: run did not finish", $time);
    results;
  end

  // Main sequence: reset values, corner cases, random traffic, lock pin.
  initial
  begin
    fail_count = 0;
    num_checks = 0;
    lfsr = 32'h404c;
    arst_n_i = 1'b0;
    req = '0;
    pin_p0 = 3'h2;
    pin_p2 = 10'h155;
    tsrc = '0;
    {ovr, ten, rx, bgen, cauto} = 5'h01;
    {p2hi, cap, p2lo, tmux, bg} = '0;
    p0 = 3'h1;
    repeat (12) @(negedge clk_sys_i);
    arst_n_i = 1'b1;
    @(negedge clk_sys_i);
    for (int a = 8'h13; a <= 8'h1f; a++)
      rd(a[7:0]);
    rd(8'hff);
    $display("test reset values done");
    wr(8'h18, 8'h00);
    rd(8'h18);
    wr(8'h18, 8'hff);
    wr(8'h18, 8'h1f);
    wr(8'h14, 8'hff);
    wr(8'h16, 8'hff);
    wr(8'h17, 8'hf1);
    rd(8'h17);
    wr(8'h1a, 8'hff);
    rd(8'h1a);
    wr(8'h1a, 8'h80);
    wr(8'h1a, 8'h80);
    rd(8'h1a);
    rd(8'h1a);
    wr(8'h1b, 8'h3f);
    wr(8'h1b, 8'h80);
    wr(8'h14, 8'h00);
    $display("test corner cases done");
    repeat (200)
    begin
      ra = 8'h14 + {4'h0, lfsr[19:16] % 4'hb};
      rd_dat = lfsr[27:20];
      if (ra == 8'h1b)
        rd_dat[6] = 1'b0;
      if (lfsr[28])
        wr(ra, rd_dat);
      else
        rd(ra);
      lfsr = lfsr_next(lfsr);
    end
    $display("test random traffic done");
    wr(8'h17, 8'h00);
    idle;
    for (int v = 1; v >= 0; v--)
    begin
      tsrc.pll_locked = v[0];
      tsrc.crystal_osc_output = ~v[0];
      repeat (4) @(negedge clk_sys_i);
      chk_bit(lock_pin, v[0], "lock status");
    end
    wr(8'h17, 8'h08);
    idle;
    for (int v = 1; v >= 0; v--)
    begin
      tsrc.crystal_osc_output = v[0];
      tsrc.pll_locked = ~v[0];
      repeat (4) @(negedge clk_sys_i);
      chk_bit(lock_pin, v[0], "oscillator");
    end
    // The unselected oscillator keeps toggling so a wrong pick of it shows in the count.
    for (int s = 1; s < 4; s++)
    begin
      wr(8'h17, {4'h0, 1'b1, s[1:0], 1'b0});
      idle;
      repeat (6) @(negedge clk_sys_i);
      last = lock_pin;
      cnt = 8'h00;
      for (int t = 0; t < 40; t++)
      begin
        tsrc.crystal_osc_output = ~tsrc.crystal_osc_output;
        if (t < 32 && t % 4 == 0)
        begin
          if (s == 1)
            tsrc.pump_up = ~tsrc.pump_up;
          if (s == 2)
            tsrc.detector_ref = ~tsrc.detector_ref;
          if (s == 3)
            tsrc.feedback_clock = ~tsrc.feedback_clock;
        end
        @(negedge clk_sys_i);
        if (lock_pin !== last)
          cnt++;
        last = lock_pin;
      end
      chk_byte(cnt, 8'h04, "halved clock edges");
    end
    $display("test lock pin done");
    idle;
    results;
  end
endmodule
`default_nettype wire
